// ===== bench/rrf_mb_master.sv
/*
  modbus master model: decoded requests, reset coil pulses.
  assumes answers come one cycle after the request edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rrf_mb_master (
  input wire logic i_clk,
  input wire logic i_resp,
  input wire logic i_exc,
  input wire logic [15:0] i_rdata,
  output logic o_valid,
  output logic [7:0] o_node,
  output logic [7:0] o_func,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata
);
  logic got_resp;
  logic got_exc;
  logic [15:0] got_data;
  initial begin
    o_valid = 1'b0;
    o_node = 8'h00;
    o_func = 8'h00;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
  end
////////////////////////////////////////
  // fields go to their inverse once released
  task automatic send(input [7:0] n, input [7:0] f, input [15:0] a,
                      input [15:0] d);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_node <= n;
    o_func <= f;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_node <= ~n;
    o_func <= ~f;
    o_addr <= ~a;
    o_wdata <= ~d;
    @(posedge i_clk);
    got_resp = i_resp;
    got_exc = i_exc;
    got_data = i_rdata;
  endtask
  // coil on, resent every scan, then off unless kept
  task automatic pulse(input int n, input bit keep);
    send(8'h01, 8'h05, 16'h0000, 16'hFF00);
    repeat (n / 10) begin
      repeat (8) @(posedge i_clk);
      send(8'h01, 8'h05, 16'h0000, 16'hFF00);
    end
    if (!keep)
      send(8'h01, 8'h05, 16'h0000, 16'h0000);
  endtask
endmodule
`default_nettype wire

// ===== bench/rrf_top_bench.sv
/*
  self-checking bench of rrf_top with a modbus master model.
  assumes shortened pulse window 50..300 cycles, blink 8 cycles.
*/
`include "rrf_map.vh"
`timescale 1ns/100ps
`default_nettype none
module rrf_top_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] chan = 4'hF;
  logic [3:0] rec = 4'h0;
  logic cpu = 1'b0;
  logic sup = 1'b0;
  logic trip = 1'b0;
  logic ce = 1'b1;
  logic stf = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, mb_valid, mb_resp, mb_exc;
  wire [7:0] mb_node, mb_func;
  wire [15:0] mb_addr, mb_wdata, mb_rdata;
  wire [3:0] safe;
  wire led, run, nonrec, rexec;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int check_count = 0;
  int exec_cnt = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (rexec === 1'b1) exec_cnt <= exec_cnt + 1;
  rrf_top #(.PULSE_MIN_CYC(32'h32), .PULSE_MAX_CYC(32'h12C),
    .BLINK_CYC(32'h8)) uut (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_mb_valid(mb_valid), .i_mb_node(mb_node),
    .i_mb_func(mb_func), .i_mb_addr(mb_addr), .i_mb_wdata(mb_wdata),
    .o_mb_resp(mb_resp), .o_mb_exc(mb_exc), .o_mb_rdata(mb_rdata),
    .i_chan_in(chan), .i_rec_cause(rec), .i_cpu_async(cpu),
    .i_supply_drop(sup), .i_out_trip(trip), .i_selftest_fail(stf),
    .o_safe_out(safe), .o_fault_led(led), .o_run_mode(run),
    .o_nonrec(nonrec), .o_reset_exec(rexec));
  rrf_mb_master mdl (
    .i_clk(clk), .i_resp(mb_resp), .i_exc(mb_exc), .i_rdata(mb_rdata),
    .o_valid(mb_valid), .o_node(mb_node), .o_func(mb_func),
    .o_addr(mb_addr), .o_wdata(mb_wdata));
////////////////////////////////////////
  task chk(input [31:0] g, input [31:0] x);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input bit w, input [7:0] a, input [31:0] d,
           output [31:0] rd, output er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task do_reset;
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (30) @(posedge clk);
  endtask
  task t_modbus;
    apb(0, `RRF_A_STATUS, 0, r, e);
    chk(r[3:0], `RRF_S_RUN);
    mdl.send(8'h02, 8'h01, 16'h0000, 16'h0000);
    chk(mdl.got_resp, 0);
    mdl.send(8'h01, 8'h01, 16'h01FF, 16'h0000);
    chk({mdl.got_resp, mdl.got_exc}, 2'h2);
    mdl.send(8'h01, 8'h01, 16'h0200, 16'h0000);
    chk({mdl.got_resp, mdl.got_exc}, 2'h3);
    apb(0, 8'h40, 0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
  endtask
  task t_reset;
    int c;
    c = exec_cnt;
    mdl.pulse(100, 0);
    repeat (6) @(posedge clk);
    chk(exec_cnt - c, 1);
    mdl.pulse(20, 0);
    repeat (6) @(posedge clk);
    chk(exec_cnt - c, 1);
    mdl.pulse(400, 1);
    apb(0, `RRF_A_STATUS, 0, r, e);
    chk(r[`RRF_B_RSTFLT], 1);
    mdl.send(8'h01, 8'h05, 16'h0000, 16'h0000);
    repeat (6) @(posedge clk);
    chk(exec_cnt - c, 1);
  endtask
  task t_rec;
    int h;
    rec <= 4'h2;
    repeat (6) @(posedge clk);
    chk(safe, 4'hD);
    apb(0, `RRF_A_STATUS, 0, r, e);
    chk(r[`RRF_B_RECANY], 1);
    h = 0;
    repeat (32) begin
      @(posedge clk);
      h += led;
    end
    chk(h, 16);
    apb(1, `RRF_A_CTRL, 0, r, e);
    repeat (2) @(posedge clk);
    chk(run, 0);
    apb(1, `RRF_A_CTRL, 1, r, e);
    rec <= 4'h0;
    repeat (6) @(posedge clk);
    chk(safe, 4'hD);
    chan <= 4'hD;
    repeat (6) @(posedge clk);
    chan <= 4'hF;
    repeat (6) @(posedge clk);
    chk(safe, 4'hF);
  endtask
  task t_nonrec;
    int c;
    for (int k = 0; k < 3; k++) begin
      do_reset;
      {cpu, sup, trip} <= 3'h4 >> k;
      repeat (6) @(posedge clk);
      {cpu, sup, trip} <= 3'h0;
      repeat (4) @(posedge clk);
      chk({nonrec, led, run, safe}, 7'h60);
    end
    apb(1, `RRF_A_CTRL, 1, r, e);
    apb(0, `RRF_A_STATUS, 0, r, e);
    chk({r[`RRF_B_REFUSED], run}, 2'h2);
    apb(0, `RRF_A_CAUSE, 0, r, e);
    chk(r[3:0], 4'h8);
    c = exec_cnt;
    mdl.pulse(100, 0);
    repeat (6) @(posedge clk);
    chk({exec_cnt - c, nonrec, led}, 3'h3);
    apb(0, `RRF_A_LOGCNT, 0, r, e);
    chk(r, 1);
    mdl.send(8'h01, 8'h03, 16'h0350, 16'h0000);
    chk(mdl.got_data, 1);
    do_reset;
    chk({nonrec, run}, 2'h1);
  endtask
  task t_ce;
    stf <= 1'b1;
    do_reset;
    stf <= 1'b0;
    apb(0, `RRF_A_CAUSE, 0, r, e);
    chk({r[3:0], run}, 5'h2);
    do_reset;
    ce <= 1'b0;
    trip <= 1'b1;
    repeat (8) @(posedge clk);
    chk(nonrec, 0);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    trip <= 1'b0;
    chk(nonrec, 1);
  endtask
  task give_verdict;
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    do_reset;
    t_modbus;
    t_reset;
    t_rec;
    t_nonrec;
    t_ce;
    give_verdict;
  end
  initial begin
    #300000;
    mismatches++;
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== bench/rrf_top_monitor.sv
/*
  concurrent checks on the ports of rrf_top.
  assumes it is bound into rrf_top; one clock, i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rrf_top_monitor #(
  parameter NCH = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_mb_valid,
  input wire logic [7:0] i_mb_node,
  input wire logic [7:0] i_mb_func,
  input wire logic [15:0] i_mb_addr,
  input wire logic [15:0] i_mb_wdata,
  input wire logic [NCH-1:0] i_rec_cause,
  input wire logic o_pready,
  input wire logic o_mb_resp,
  input wire logic [NCH-1:0] o_safe_out,
  input wire logic o_fault_led,
  input wire logic o_run_mode,
  input wire logic o_nonrec,
  input wire logic o_reset_exec
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire node_ok = i_mb_valid && i_mb_node == 8'h01;
  wire off_wr = node_ok && i_mb_func == 8'h05 && i_mb_addr == 16'h0000
    && i_mb_wdata == 16'h0000;
////////////////////////////////////////
  property p_resp;
    node_ok |=> o_mb_resp;
  endproperty
  a_resp: assert property (p_resp) else $error("no answer");
  property p_noresp;
    i_mb_valid && i_mb_node != 8'h01 |=> !o_mb_resp;
  endproperty
  a_noresp: assert property (p_noresp) else $error("foreign node");
  property p_exec;
    o_reset_exec |-> $past(off_wr, 3);
  endproperty
  a_exec: assert property (p_exec) else $error("stray reset");
  property p_pulse;
    o_reset_exec |=> !o_reset_exec;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long reset");
  property p_sticky;
    o_nonrec |=> o_nonrec;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault lost");
  property p_led;
    o_nonrec [*2] |-> o_fault_led;
  endproperty
  a_led: assert property (p_led) else $error("led not steady");
  property p_safe;
    o_nonrec [*2] |-> !o_run_mode && o_safe_out == 0;
  endproperty
  a_safe: assert property (p_safe) else $error("not safe");
  property p_noexec;
    o_nonrec [*4] |-> !o_reset_exec;
  endproperty
  a_noexec: assert property (p_noexec) else $error("reset taken");
  property p_rec;
    i_rec_cause[1] [*5] |-> !o_safe_out[1];
  endproperty
  a_rec: assert property (p_rec) else $error("output kept");
  property p_apb;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_apb: assert property (p_apb) else $error("no pready");
endmodule
bind rrf_top rrf_top_monitor #(.NCH(NCH)) u_mon (
  .i_clk, .i_arst_n, .i_psel, .i_penable, .i_mb_valid, .i_mb_node,
  .i_mb_func, .i_mb_addr, .i_mb_wdata, .i_rec_cause, .o_pready,
  .o_mb_resp, .o_safe_out, .o_fault_led, .o_run_mode, .o_nonrec,
  .o_reset_exec
);
`default_nettype wire

// ===== hw/rrf_fault_log.v
/*
  circular log of recent nonrecoverable fault entries.
  assumes one write pulse per event and a read index from the owner.
*/
`timescale 1ns/100ps
`default_nettype none
module rrf_fault_log #(
  parameter DEPTH = 12,
  parameter AW = 4,
  parameter DW = 16
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_wr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_ridx,
  output reg [DW-1:0] o_rdata,
  output reg [AW-1:0] o_count
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] pos;
  integer k;
  ////////////////////////////////////////////////////////////////////
  // index 0 is the newest entry
  always @* begin
    if (wptr > i_ridx) begin
      pos = wptr - i_ridx - {{(AW-1){1'b0}}, 1'b1};
    end else begin
      pos = wptr + DEPTH[AW-1:0] - i_ridx - {{(AW-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr <= {AW{1'b0}};
      o_count <= {AW{1'b0}};
      o_rdata <= {DW{1'b0}};
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem[k] <= {DW{1'b0}};
      end
    end else if (i_ce) begin
      if (i_wr) begin
        mem[wptr] <= i_wdata;
        if (wptr == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
          wptr <= {AW{1'b0}};
        end else begin
          wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (o_count != DEPTH[AW-1:0]) begin
          o_count <= o_count + {{(AW-1){1'b0}}, 1'b1};
        end
      end
      if (i_ridx < o_count) begin
        o_rdata <= mem[pos];
      end else begin
        o_rdata <= {DW{1'b0}};
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/rrf_map.vh
/*
  constants of the remote reset and fault handling block: apb map,
  modbus codes, times and state codes.
  assumes it is included by bare name from the rrf design files.
*/
`ifndef RRF_MAP_VH
`define RRF_MAP_VH
////////////////////////////////////////////////////////////////////////
// timing
`define RRF_CLK_HZ 100000000
`define RRF_CYC_PER_MS (`RRF_CLK_HZ / 1000)
`define RRF_PULSE_MIN_MS 500
`define RRF_PULSE_MAX_MS 3000
`define RRF_BLINK_MS 250
`define RRF_SELFTEST_CYC 5'h10
////////////////////////////////////////////////////////////////////////
// apb register byte offsets
`define RRF_A_CTRL 8'h00
`define RRF_A_STATUS 8'h04
`define RRF_A_CAUSE 8'h08
`define RRF_A_LOGCNT 8'h0C
`define RRF_A_LOGIDX 8'h10
`define RRF_A_LOGDAT 8'h14
`define RRF_A_CLEAR 8'h18
// field positions
`define RRF_B_RUN 0
`define RRF_B_REFUSED 4
`define RRF_B_NONREC 5
`define RRF_B_RSTFLT 6
`define RRF_B_RECANY 7
`define RRF_B_RECVEC 8
////////////////////////////////////////////////////////////////////////
// modbus
`define RRF_NODE 8'h01
`define RRF_FC_RD_COIL 8'h01
`define RRF_FC_RD_HOLD 8'h03
`define RRF_FC_WR_COIL 8'h05
`define RRF_COIL_ON 16'hFF00
`define RRF_COIL_OFF 16'h0000
`define RRF_COIL_RESET 16'h0000
`define RRF_COIL_LAST 16'h01FF
`define RRF_COIL_CPU 16'h0108
`define RRF_COIL_OUT 16'h010A
`define RRF_COIL_PWR 16'h010B
`define RRF_HOLD_LOG 16'h0350
////////////////////////////////////////////////////////////////////////
// nonrecoverable cause bits
`define RRF_NC_W 4
`define RRF_NC_TEST 0
`define RRF_NC_CPU 1
`define RRF_NC_PWR 2
`define RRF_NC_OUT 3
////////////////////////////////////////////////////////////////////////
// states, one-hot
`define RRF_S_INIT 4'h1
`define RRF_S_RUN 4'h2
`define RRF_S_PROG 4'h4
`define RRF_S_FAULT 4'h8
`endif

// ===== hw/rrf_pulse_win.v
/*
  measures how long a level stays high and judges each high pulse
  against a min/max window on its fall.
  assumes level comes from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rrf_pulse_win #(
  parameter W = 32,
  parameter [W-1:0] MIN_CYC = 32'd50000000,
  parameter [W-1:0] MAX_CYC = 32'd300000000
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_level,
  output reg o_accept,
  output reg o_too_long
);
  reg prev;
  reg [W-1:0] cnt;
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev <= 1'b0;
      cnt <= {W{1'b0}};
      o_accept <= 1'b0;
      o_too_long <= 1'b0;
    end else if (i_ce) begin
      prev <= i_level;
      o_accept <= 1'b0;
      if (i_level && !prev) begin
        cnt <= {{(W-1){1'b0}}, 1'b1};
      end else if (i_level && cnt <= MAX_CYC) begin
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
      if (!i_level && prev) begin
        o_accept <= (cnt >= MIN_CYC) && (cnt <= MAX_CYC);
      end
      o_too_long <= i_level && (cnt > MAX_CYC);
    end
  end
endmodule
`default_nettype wire

// ===== hw/rrf_top.v
/*
  remote reset and fault handling of a safety relay: reset coil pulse
  check, fault classes, modes, indicator, fault log, apb registers.
  assumes decoded modbus requests on i_clk; fault and channel inputs are
  pins and get synchronised here.
*/
// Notes on behaviour
// - reset only on 0-1-0 pulse in window
// - answer only node address 1
// - faults split recoverable/nonrecoverable; recoverable self-clear
// - clear recoverable after cause gone, input cycled
// - recoverable fault drops only its own output
// - channel, reset and sequence faults are recoverable; code has no sequence fault, only channel (rec_latch) and reset (rst_fault)
// - nonrecoverable holds until power-up self-test
// - cpu async, supply drop, output trip: nonrecoverable
// - led flashes recoverable, steady nonrecoverable
// - nonrecoverable forces program mode, refuses changes
// - recoverable fault still allows program mode
// - keep readable log of nonrecoverable faults
// - reset fault when coil high over 3000 ms
// - coils 1..512, log as 16-bit holding registers; code serves only the log count, at holding register 0x0350
`include "rrf_map.vh"
`timescale 1ns/100ps
`default_nettype none
module rrf_top #(
  parameter NCH = 4,
  parameter [31:0] PULSE_MIN_CYC = `RRF_PULSE_MIN_MS * `RRF_CYC_PER_MS,
  parameter [31:0] PULSE_MAX_CYC = `RRF_PULSE_MAX_MS * `RRF_CYC_PER_MS,
  parameter [31:0] BLINK_CYC = `RRF_BLINK_MS * `RRF_CYC_PER_MS,
  parameter LOG_DEPTH = 12
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_ce,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_mb_valid,
  input wire [7:0] i_mb_node,
  input wire [7:0] i_mb_func,
  input wire [15:0] i_mb_addr,
  input wire [15:0] i_mb_wdata,
  output reg o_mb_resp,
  output reg o_mb_exc,
  output reg [15:0] o_mb_rdata,
  input wire [NCH-1:0] i_chan_in,
  input wire [NCH-1:0] i_rec_cause,
  input wire i_cpu_async,
  input wire i_supply_drop,
  input wire i_out_trip,
  input wire i_selftest_fail,
  output reg [NCH-1:0] o_safe_out,
  output reg o_fault_led,
  output reg o_run_mode,
  output reg o_nonrec,
  output reg o_reset_exec
);
  localparam SW = 2 * NCH + 4;
  localparam [3:0] S_INIT = `RRF_S_INIT;
  localparam [3:0] S_RUN = `RRF_S_RUN;
  localparam [3:0] S_PROG = `RRF_S_PROG;
  localparam [3:0] S_FAULT = `RRF_S_FAULT;
  ////////////////////////////////////////////////////////////////////
  reg [SW-1:0] sync1, sync2;
  wire [NCH-1:0] chan = sync2[NCH-1:0];
  wire [NCH-1:0] cause = sync2[2*NCH-1:NCH];
  wire cpu_async = sync2[2*NCH];
  wire supply_drop = sync2[2*NCH+1];
  wire out_trip = sync2[2*NCH+2];
  wire test_fail = sync2[2*NCH+3];
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= {SW{1'b0}};
      sync2 <= {SW{1'b0}};
    end else if (i_ce) begin
      sync1 <= {i_selftest_fail, i_out_trip, i_supply_drop, i_cpu_async,
                i_rec_cause, i_chan_in};
      sync2 <= sync1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  function reg_hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      reg_hit = (addr == off);
    end
  endfunction
  function [15:0] mb_bit;
    input b;
    begin
      mb_bit = {15'h0000, b};
    end
  endfunction
  ////////////////////////////////////////////////////////////////////
  reg [3:0] state, next_state;
  reg [4:0] test_cnt;
  reg [`RRF_NC_W-1:0] nc_cause, next_nc;
  reg [NCH-1:0] rec_latch, seen_off;
  reg reset_coil, rst_fault, refused, blink_phase;
  reg [3:0] log_idx;
  reg [31:0] blink_cnt;
  wire pulse_ok, pulse_long;
  wire [15:0] log_rdata;
  wire [3:0] log_count;
  wire nonrec = |nc_cause;
  wire rec_any = (|rec_latch) | rst_fault;
  wire apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  wire mode_wr = apb_wr && reg_hit(i_paddr, `RRF_A_CTRL);
  wire want_run = i_pwdata[`RRF_B_RUN];
  wire mb_me = i_mb_valid && (i_mb_node == `RRF_NODE);
  wire coil_wr = mb_me && (i_mb_func == `RRF_FC_WR_COIL) &&
                 (i_mb_addr == `RRF_COIL_RESET);
  wire [`RRF_NC_W-1:0] nc_new = next_nc & ~nc_cause;
  wire coil_val = (i_mb_addr == `RRF_COIL_RESET) ? reset_coil :
                  (i_mb_addr == `RRF_COIL_CPU) ? nc_cause[`RRF_NC_CPU] :
                  (i_mb_addr == `RRF_COIL_OUT) ? nc_cause[`RRF_NC_OUT] :
                  (i_mb_addr == `RRF_COIL_PWR) && nc_cause[`RRF_NC_PWR];
  ////////////////////////////////////////////////////////////////////
  always @* begin
    next_nc = nc_cause;
    next_nc[`RRF_NC_CPU] = nc_cause[`RRF_NC_CPU] | cpu_async;
    next_nc[`RRF_NC_PWR] = nc_cause[`RRF_NC_PWR] | supply_drop;
    next_nc[`RRF_NC_OUT] = nc_cause[`RRF_NC_OUT] | out_trip;
    if (state == S_INIT && test_cnt == 5'd0) begin
      next_nc[`RRF_NC_TEST] = nc_cause[`RRF_NC_TEST] | test_fail;
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @* begin
    next_state = state;
    case (state)
      S_INIT: begin
        if (test_cnt == 5'd0) begin
          next_state = (|next_nc) ? S_FAULT : S_RUN;
        end
      end
      S_RUN, S_PROG: begin
        if (|next_nc) begin
          next_state = S_FAULT;
        end else if (mode_wr) begin
          next_state = want_run ? S_RUN : S_PROG;
        end
      end
      S_FAULT: begin
        next_state = S_FAULT;
      end
      default: begin
        next_state = S_FAULT;
      end
    endcase
  end
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= S_INIT;
      test_cnt <= `RRF_SELFTEST_CYC;
      nc_cause <= {`RRF_NC_W{1'b0}};
      refused <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      nc_cause <= next_nc;
      if (state == S_INIT && test_cnt != 5'd0) begin
        test_cnt <= test_cnt - 5'd1;
      end
      if (mode_wr && state == S_FAULT) begin
        refused <= 1'b1;
      end else if (apb_wr && reg_hit(i_paddr, `RRF_A_CLEAR) &&
                   i_pwdata[`RRF_B_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec_latch <= {NCH{1'b0}};
      seen_off <= {NCH{1'b0}};
    end else if (i_ce) begin
      rec_latch <= cause | (rec_latch & ~(seen_off & chan));
      seen_off <= rec_latch & ~cause & (seen_off | ~chan) &
                  ~(seen_off & chan);
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reset_coil <= 1'b0;
      rst_fault <= 1'b0;
    end else if (i_ce) begin
      if (coil_wr && i_mb_wdata == `RRF_COIL_ON) begin
        reset_coil <= 1'b1;
      end else if (coil_wr && i_mb_wdata == `RRF_COIL_OFF) begin
        reset_coil <= 1'b0;
      end
      rst_fault <= pulse_long | (rst_fault & reset_coil);
    end
  end
  rrf_pulse_win #(
    .W(32),
    .MIN_CYC(PULSE_MIN_CYC),
    .MAX_CYC(PULSE_MAX_CYC)
  ) u_pulse (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_level(reset_coil),
    .o_accept(pulse_ok),
    .o_too_long(pulse_long)
  );
  ////////////////////////////////////////////////////////////////////
  rrf_fault_log #(
    .DEPTH(LOG_DEPTH),
    .AW(4),
    .DW(16)
  ) u_log (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_wr(|nc_new),
    .i_wdata({12'h000, nc_new}),
    .i_ridx(log_idx),
    .o_rdata(log_rdata),
    .o_count(log_count)
  );
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blink_cnt <= 32'h00000000;
      blink_phase <= 1'b0;
      o_fault_led <= 1'b0;
      o_safe_out <= {NCH{1'b0}};
      o_run_mode <= 1'b0;
      o_nonrec <= 1'b0;
      o_reset_exec <= 1'b0;
    end else if (i_ce) begin
      if (blink_cnt >= BLINK_CYC - 32'h00000001) begin
        blink_cnt <= 32'h00000000;
        blink_phase <= ~blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 32'h00000001;
      end
      o_fault_led <= nonrec | (rec_any & blink_phase);
      o_safe_out <= (state == S_RUN && !nonrec) ?
                    (chan & ~rec_latch & ~cause) : {NCH{1'b0}};
      o_run_mode <= (state == S_RUN);
      o_nonrec <= nonrec;
      o_reset_exec <= pulse_ok && !nonrec && !rst_fault &&
                      (state != S_INIT);
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mb_resp <= 1'b0;
      o_mb_exc <= 1'b0;
      o_mb_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_mb_resp <= mb_me;
      o_mb_exc <= 1'b0;
      o_mb_rdata <= 16'h0000;
      if (mb_me) begin
        case (i_mb_func)
          `RRF_FC_RD_COIL: begin
            o_mb_exc <= (i_mb_addr > `RRF_COIL_LAST);
            o_mb_rdata <= mb_bit(coil_val);
          end
          `RRF_FC_RD_HOLD: begin
            if (i_mb_addr == `RRF_HOLD_LOG) begin
              o_mb_rdata <= {12'h000, log_count};
            end else begin
              o_mb_exc <= 1'b1;
            end
          end
          `RRF_FC_WR_COIL: begin
            o_mb_exc <= (i_mb_addr > `RRF_COIL_LAST);
            o_mb_rdata <= i_mb_wdata;
          end
          default: begin
            o_mb_exc <= 1'b1;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  wire apb_setup = i_psel && !i_penable;
  wire known = (i_paddr[1:0] == 2'b00) && (i_paddr <= `RRF_A_CLEAR);
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (reg_hit(i_paddr, `RRF_A_CTRL)) begin
      rd_mux[`RRF_B_RUN] = (state == S_RUN);
    end else if (reg_hit(i_paddr, `RRF_A_STATUS)) begin
      rd_mux[3:0] = state;
      rd_mux[`RRF_B_REFUSED] = refused;
      rd_mux[`RRF_B_NONREC] = nonrec;
      rd_mux[`RRF_B_RSTFLT] = rst_fault;
      rd_mux[`RRF_B_RECANY] = rec_any;
      rd_mux[`RRF_B_RECVEC +: NCH] = rec_latch;
    end else if (reg_hit(i_paddr, `RRF_A_CAUSE)) begin
      rd_mux[`RRF_NC_W-1:0] = nc_cause;
    end else if (reg_hit(i_paddr, `RRF_A_LOGCNT)) begin
      rd_mux[3:0] = log_count;
    end else if (reg_hit(i_paddr, `RRF_A_LOGIDX)) begin
      rd_mux[3:0] = log_idx;
    end else if (reg_hit(i_paddr, `RRF_A_LOGDAT)) begin
      rd_mux[15:0] = log_rdata;
    end
  end
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      log_idx <= 4'h0;
    end else if (i_ce) begin
      o_pready <= apb_setup;
      o_pslverr <= apb_setup && !known;
      if (apb_setup && !i_pwrite) begin
        o_prdata <= rd_mux;
      end
      if (apb_wr && reg_hit(i_paddr, `RRF_A_LOGIDX)) begin
        log_idx <= i_pwdata[3:0];
      end
    end
  end
endmodule
`default_nettype wire
